// File: src/csw_clock_switch.v
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "csw_defs.vh"
module csw_clock_switch #(
  parameter [2:0] RESET_SOURCE  = 3'h6,
  parameter [3:0] RESET_DIVIDER = 4'h4,
  parameter [2:0] EXT_MODE      = 3'h0
) (
  // clock and reset
  input  wire        mclk,
  input  wire        resetn,
  // avalon-mm slave
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // oscillator ready inputs (asynchronous)
  input  wire        external_ready,
  input  wire        fast_internal_ready,
  input  wire        slow_internal_ready,
  input  wire        secondary_ready,
  input  wire        adc_rc_ready,
  input  wire        multiplier_locked,
  // clock tree control
  output reg  [2:0]  active_source,
  output reg  [3:0]  active_divider,
  output reg  [2:0]  external_mode_config,
  output reg         secondary_high_power,
  output reg         secondary_bypass,
  output reg         secondary_xtal_drive,
  output reg         switch_irq_pulse,
  output reg         irq
);
  // ----------------------------------------
  // ready input synchronisers
  // ----------------------------------------
  reg  [5:0] rdy_s1_q;
  reg  [5:0] rdy_s2_q;
  wire [5:0] rdy_raw;
  assign rdy_raw = {multiplier_locked, adc_rc_ready, secondary_ready,
                    slow_internal_ready, fast_internal_ready, external_ready};
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdy_s1_q <= 6'h00;
      rdy_s2_q <= 6'h00;
    end else begin
      rdy_s1_q <= rdy_raw;
      rdy_s2_q <= rdy_s1_q;
    end
  end
  wire ext_r  = rdy_s2_q[0];
  wire fast_r = rdy_s2_q[1];
  wire slow_r = rdy_s2_q[2];
  wire sec_r  = rdy_s2_q[3];
  wire adc_r  = rdy_s2_q[4];
  wire pll_r  = rdy_s2_q[5];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [2:0] req_src_q;
  reg  [3:0] req_div_q;
  reg  [2:0] cur_src_q;
  reg  [3:0] cur_div_q;
  reg        hold_q;
  reg        pwr_q;
  reg        byp_q;
  reg  [1:0] ist_q;
  reg  [1:0] imask_q;
  reg        nrdy_prev_q;
  reg        boot_q;

  // ----------------------------------------
  // request source decode
  // ----------------------------------------
  wire [2:0] wr_src = avs_writedata[`CSW_SRC_HI:`CSW_SRC_LO];
  wire       wr_rsv = (wr_src == `CSW_SRC_RSV5) || (wr_src == `CSW_SRC_RSV2);
  wire [2:0] wr_src_fix = wr_rsv ? `CSW_SRC_FAST : wr_src;
  wire       acc = !avs_waitrequest;
  wire       wr_req = acc && avs_write && (avs_address == `CSW_OFF_REQ);
  wire       wr_ctl = acc && avs_write && (avs_address == `CSW_OFF_CTL);
  wire       wr_ist = acc && avs_write && (avs_address == `CSW_OFF_IRQ_STAT);
  wire       wr_imk = acc && avs_write && (avs_address == `CSW_OFF_IRQ_MASK);

  // ----------------------------------------
  // switch status
  // ----------------------------------------
  reg sel_rdy;
  always @* begin
    case (req_src_q)
      `CSW_SRC_EXT:      sel_rdy = ext_r;
      `CSW_SRC_FAST:     sel_rdy = fast_r;
      `CSW_SRC_SLOW:     sel_rdy = slow_r;
      `CSW_SRC_SEC:      sel_rdy = sec_r;
      `CSW_SRC_EXT_PLL:  sel_rdy = ext_r && pll_r;
      `CSW_SRC_FAST_PLL: sel_rdy = fast_r && pll_r;
      default:           sel_rdy = fast_r;
    endcase
  end
  wire busy     = (req_src_q != cur_src_q) || (req_div_q != cur_div_q);
  wire done     = !busy;
  wire new_rdy  = busy && sel_rdy && !boot_q;
  wire do_sw    = new_rdy && !hold_q;
  wire nrdy_rise = new_rdy && !nrdy_prev_q;

  // ----------------------------------------
  // request, current and control state
  // ----------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      req_src_q   <= 3'h0;
      req_div_q   <= 4'h0;
      cur_src_q   <= 3'h0;
      cur_div_q   <= 4'h0;
      hold_q      <= 1'b0;
      pwr_q       <= 1'b0;
      byp_q       <= 1'b0;
      nrdy_prev_q <= 1'b0;
      boot_q      <= 1'b1;
    end else begin
      nrdy_prev_q <= new_rdy;
      if (boot_q) begin
        boot_q    <= 1'b0;
        req_src_q <= RESET_SOURCE;
        req_div_q <= RESET_DIVIDER;
        cur_src_q <= RESET_SOURCE;
        cur_div_q <= RESET_DIVIDER;
      end else begin
        if (wr_req) begin
          req_src_q <= wr_src_fix;
          req_div_q <= avs_writedata[`CSW_DIV_HI:`CSW_DIV_LO];
        end
        if (do_sw) begin
          cur_src_q <= req_src_q;
          cur_div_q <= req_div_q;
        end
      end
      if (wr_ctl) begin
        hold_q <= avs_writedata[`CSW_HOLD_BIT];
        pwr_q  <= avs_writedata[`CSW_PWR_BIT];
        byp_q  <= avs_writedata[`CSW_BYP_BIT];
      end
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  wire [1:0] ev = {do_sw, nrdy_rise};
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ist_q   <= `CSW_IRQ_RESET;
      imask_q <= `CSW_IRQ_RESET;
    end else begin
      ist_q <= (ist_q & ~(wr_ist ? avs_writedata[1:0] : 2'h0)) | ev;
      if (wr_imk)
        imask_q <= avs_writedata[1:0];
    end
  end

  // ----------------------------------------
  // bus slave: one wait cycle per access
  // ----------------------------------------
  reg [7:0] rd_mux;
  always @* begin
    case (avs_address)
      `CSW_OFF_REQ: rd_mux = {1'b0, req_src_q, req_div_q};
      `CSW_OFF_CUR: rd_mux = {1'b0, cur_src_q, cur_div_q};
      `CSW_OFF_CTL: rd_mux = {hold_q, pwr_q, byp_q, done, new_rdy, 3'h0};
      `CSW_OFF_RDY: rd_mux = {ext_r, fast_r, 1'b0, slow_r, sec_r, adc_r, 1'b0,
                              pll_r};
      `CSW_OFF_IRQ_STAT: rd_mux = {6'h00, ist_q};
      `CSW_OFF_IRQ_MASK: rd_mux = {6'h00, imask_q};
      default: rd_mux = 8'h00;
    endcase
  end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= {24'h000000, rd_mux};
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      active_source        <= 3'h0;
      active_divider       <= 4'h0;
      external_mode_config <= 3'h0;
      secondary_high_power <= 1'b0;
      secondary_bypass     <= 1'b0;
      secondary_xtal_drive <= 1'b0;
      switch_irq_pulse     <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      active_source        <= cur_src_q;
      active_divider       <= cur_div_q;
      external_mode_config <= EXT_MODE;
      secondary_high_power <= pwr_q && !byp_q;
      secondary_bypass     <= byp_q;
      secondary_xtal_drive <= !byp_q;
      switch_irq_pulse     <= nrdy_rise;
      irq                  <= |(ist_q & imask_q);
    end
  end
endmodule
`default_nettype wire

// File: src/csw_defs.vh
`ifndef CSW_DEFS_VH
`define CSW_DEFS_VH
// ----------------------------------------
// register word offsets (byte address)
// ----------------------------------------
`define CSW_OFF_REQ      5'h00
`define CSW_OFF_CUR      5'h04
`define CSW_OFF_CTL      5'h08
`define CSW_OFF_RDY      5'h0C
`define CSW_OFF_IRQ_STAT 5'h10
`define CSW_OFF_IRQ_MASK 5'h14
// ----------------------------------------
// field positions
// ----------------------------------------
`define CSW_SRC_HI    6
`define CSW_SRC_LO    4
`define CSW_DIV_HI    3
`define CSW_DIV_LO    0
`define CSW_HOLD_BIT  7
`define CSW_PWR_BIT   6
`define CSW_BYP_BIT   5
`define CSW_DONE_BIT  4
`define CSW_NRDY_BIT  3
`define CSW_EXT_BIT   7
`define CSW_FAST_BIT  6
`define CSW_SLOW_BIT  4
`define CSW_SEC_BIT   3
`define CSW_ADC_BIT   2
`define CSW_PLL_BIT   0
// ----------------------------------------
// source and divider encodings
// ----------------------------------------
`define CSW_SRC_EXT      3'h7
`define CSW_SRC_FAST     3'h6
`define CSW_SRC_RSV5     3'h5
`define CSW_SRC_SLOW     3'h4
`define CSW_SRC_SEC      3'h3
`define CSW_SRC_RSV2     3'h2
`define CSW_SRC_EXT_PLL  3'h1
`define CSW_SRC_FAST_PLL 3'h0
`define CSW_DIV_MAX      4'h9
// ----------------------------------------
// reset values
// ----------------------------------------
`define CSW_CTL_RESET    3'h0
`define CSW_IRQ_RESET    2'h0
`endif

// File: tb/csw_chk.sv
`timescale 1ns/1ps
`default_nettype none
module csw_chk #(
  parameter [2:0] RESET_SOURCE  = 3'h6,
  parameter [3:0] RESET_DIVIDER = 4'h4,
  parameter [2:0] EXT_MODE      = 3'h0
) (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [2:0]  active_source,
  input wire logic [3:0]  active_divider,
  input wire logic [2:0]  external_mode_config,
  input wire logic        secondary_high_power,
  input wire logic        secondary_bypass,
  input wire logic        secondary_xtal_drive,
  input wire logic        switch_irq_pulse,
  input wire logic        irq
);
  logic [1:0] up_q;
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn) up_q <= 2'h0;
    else if (!up_q[1]) up_q <= up_q + 2'h1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_reset_load: assert property (up_q == 2'h1 |=> active_source == RESET_SOURCE
    && active_divider == RESET_DIVIDER) else $error("reset load");
  a_src_legal: assert property (up_q[1] |-> active_source != 3'h5
    && active_source != 3'h2) else $error("reserved source");
  a_ext_mode: assert property (up_q[1] |-> external_mode_config == EXT_MODE)
    else $error("ext mode");
  a_power_mode: assert property (secondary_high_power |-> !secondary_bypass)
    else $error("power mode");
  a_xtal_drive: assert property (up_q[1] |-> secondary_xtal_drive == !secondary_bypass)
    else $error("xtal drive");
  a_pulse_once: assert property (switch_irq_pulse |=> !switch_irq_pulse)
    else $error("pulse width");
  a_cur_read: assert property (avs_read && avs_address == 5'h04 && !avs_waitrequest
    |-> avs_readdata[7:0] == {1'b0, active_source, active_divider}) else $error("cur read");
  a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper bits");
  cover property (switch_irq_pulse);
  cover property (irq);
  cover property (secondary_bypass);
endmodule
bind csw_clock_switch csw_chk #(.RESET_SOURCE(RESET_SOURCE), .RESET_DIVIDER(RESET_DIVIDER),
  .EXT_MODE(EXT_MODE)) u_chk (.mclk, .resetn, .avs_address, .avs_read, .avs_readdata,
  .avs_waitrequest, .active_source, .active_divider, .external_mode_config,
  .secondary_high_power, .secondary_bypass, .secondary_xtal_drive, .switch_irq_pulse, .irq);
`default_nettype wire

// File: tb/csw_clock_switch_tb.sv
`timescale 1ns/1ps
`default_nettype none
module csw_clock_switch_tb;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  a_q = 5'h00;
  logic        rd_q = 1'b0;
  logic        wr_q = 1'b0;
  logic [31:0] wd_q = 32'h0;
  logic [31:0] rdata;
  logic        wait_r;
  logic [5:0]  rdy = 6'h00;
  logic        hp, byp, xt, irq;
  int          error_cnt = 0;
  int          num_checks = 0;
  logic [7:0]  exp_q[$];
  logic [31:0] seed = 32'hCDD9710F;
  always #2 mclk = ~mclk;
  csw_clock_switch u_dut (.mclk, .resetn, .avs_address(a_q), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wd_q), .avs_readdata(rdata), .avs_waitrequest(wait_r),
    .external_ready(rdy[5]), .fast_internal_ready(rdy[4]), .slow_internal_ready(rdy[3]),
    .secondary_ready(rdy[2]), .adc_rc_ready(rdy[1]), .multiplier_locked(rdy[0]),
    .active_source(), .active_divider(), .external_mode_config(),
    .secondary_high_power(hp), .secondary_bypass(byp), .secondary_xtal_drive(xt),
    .switch_irq_pulse(), .irq);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    a_q  <= a;
    wd_q <= {24'h0, d};
    wr_q <= w;
    rd_q <= !w;
    do @(posedge mclk); while (wait_r !== 1'b0);
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk)
    if (rd_q && wait_r === 1'b0) chk("readdata", exp_q.pop_front(), rdata[7:0]);
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(5'h00, 8'h64);
    rd(5'h04, 8'h64);
    rd(5'h08, 8'h10);
    rd(5'h18, 8'h00);
    seed = xs(seed);
    bus(1'b1, 5'h04, seed[7:0]);
    rd(5'h04, 8'h64);
    $display("map done");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      rdy <= seed[5:0];
      repeat (4) @(posedge mclk);
      rd(5'h0C, {seed[5:4], 1'b0, seed[3:1], 1'b0, seed[0]});
    end
    rdy <= 6'h3F;
    $display("ready done");
    bus(1'b1, 5'h08, 8'h60);
    repeat (3) @(posedge mclk);
    chk("bypass", 8'h04, {5'h0, byp, hp, xt});
    bus(1'b1, 5'h08, 8'h40);
    repeat (3) @(posedge mclk);
    chk("power", 8'h03, {5'h0, byp, hp, xt});
    rd(5'h08, 8'h50);
    $display("modes done");
    bus(1'b1, 5'h08, 8'h80);
    bus(1'b1, 5'h00, 8'h39);
    repeat (4) @(posedge mclk);
    rd(5'h04, 8'h64);
    rd(5'h08, 8'h88);
    chk("irq masked", 8'h00, {7'h0, irq});
    bus(1'b1, 5'h08, 8'h00);
    repeat (2) @(posedge mclk);
    rd(5'h04, 8'h39);
    rd(5'h08, 8'h10);
    bus(1'b1, 5'h14, 8'h03);
    repeat (3) @(posedge mclk);
    chk("irq set", 8'h01, {7'h0, irq});
    bus(1'b1, 5'h10, 8'h03);
    repeat (3) @(posedge mclk);
    chk("irq clear", 8'h00, {7'h0, irq});
    rd(5'h10, 8'h00);
    $display("switch done");
    bus(1'b1, 5'h00, 8'h50);
    rd(5'h00, 8'h60);
    repeat (2) @(posedge mclk);
    rd(5'h04, 8'h60);
    $display("reserved done");
    bus(1'b1, 5'h08, 8'h80);
    bus(1'b1, 5'h00, 8'h39);
    repeat (4) @(posedge mclk);
    rd(5'h08, 8'h88);
    bus(1'b1, 5'h00, 8'h60);
    repeat (2) @(posedge mclk);
    rd(5'h04, 8'h60);
    rd(5'h08, 8'h90);
    bus(1'b1, 5'h08, 8'h00);
    $display("abandon done");
    summarize();
  end
endmodule
`default_nettype wire
